// File: logic/fcs_pkg.sv
`default_nettype none
package fcs_pkg;
   // ------------------------------------------------------------
   // Array geometry
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int SECT_N = 4;
   localparam int SECT_SHIFT = 6;
   localparam int DEPTH = 256;

   // ------------------------------------------------------------
   // Command sequence codes
   // ------------------------------------------------------------
   localparam logic [7:0] UNLOCK_A1 = 8'hAA;
   localparam logic [7:0] UNLOCK_A2 = 8'h55;
   localparam logic [7:0] CMD_RESET = 8'hF0;
   localparam logic [7:0] CMD_PROG = 8'hA0;
   localparam logic [7:0] CMD_ERASE = 8'h80;
   localparam logic [7:0] CMD_CHIP = 8'h10;
   localparam logic [7:0] CMD_SECT = 8'h30;
   localparam logic [7:0] CMD_SUSP = 8'hB0;
   localparam logic [7:0] CMD_RESUME = 8'h30;

   // ------------------------------------------------------------
   // Status bit positions
   // ------------------------------------------------------------
   localparam int POS_POLL = 7;
   localparam int POS_BUSY = 6;
   localparam int POS_TLE = 5;
   localparam int POS_EST = 2;

   // ------------------------------------------------------------
   // Timing (cycles at 100 MHz)
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int PROG_US = 2;
   localparam int PROG_CYC = PROG_US * CLK_MHZ;
   localparam int ERASE_CYC_PER_CELL = 1;
   localparam int LIMIT_US = 40;
   localparam int LIMIT_CYC = LIMIT_US * CLK_MHZ;
   localparam int CNT_W = 16;
endpackage
`default_nettype wire

// File: logic/fcs_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fcs_if;
   // CPU access strobes
   logic wr;
   logic rd;
   logic [7:0] addr;
   logic [7:0] wdata;
   // Device answer, plus the sector write enables driven by the CPU
   logic [7:0] rdata;
   logic rvalid;
   logic [3:0] sect_wen;
   logic busy;
   modport dev (input wr, rd, addr, wdata, sect_wen, output rdata, rvalid, busy);
   modport cpu (output wr, rd, addr, wdata, sect_wen, input rdata, rvalid, busy);
endinterface
`default_nettype wire

// File: logic/fcs_device.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R01 - Erase-selected sector reads toggle bit two
// R02 - Unselected sector reads return stored bit two
// R03 - Suspended erase: selected sector reads toggle
// R04 - Suspended erase: unselected reads stored bit
// R05 - Program reads 0; erase toggles, then 1 (code: polling bit reads inverted data bit 7 in program, 0 during erase)
// R06 - Timeout: program 0, erase keeps toggling
// R07 - Return to read/reset after normal end
// R08 - Reset enters read/reset idle state
// R09 - Idle reads return array contents
// R10 - Reset command reinitialises the algorithm
// R11 - Program starts on fourth cycle write
// R12 - One byte per program, any address
// R13 - Programming only clears bits; else timeout
// R14 - Commands ignored while programming
// R15 - CPU polls last programmed address
// R16 - Polling and timeout flags change together
// R17 - Busy toggle stops when timeout rises
// R18 - Chip erase is six write cycles
// R19 - Chip erase preprograms zeros first
// R20 - Chip erase needs all sector enables
// R21 - CPU erases after reset during programming (fcs_cpu only clears its state and returns to idle)
// R22 - Timeout flag 0 within limit, 1 beyond
// R23 - Bad sequences discarded, stay idle
module fcs_device (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // CPU side
   fcs_if.dev bus,
   // Status view
   output logic algo_busy,
   output logic timed_out
);
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_PROG = 6'h02,
      ST_PREP = 6'h04,
      ST_ERASE = 6'h08,
      ST_SUSP = 6'h10,
      ST_FAIL = 6'h20
   } fcs_state_e;

   typedef struct packed {
      fcs_state_e st;
      logic [2:0] cyc;
      logic [fcs_pkg::CNT_W-1:0] tmr;
      logic [fcs_pkg::ADDR_W-1:0] pa;
      logic [fcs_pkg::DATA_W-1:0] pd;
      logic [fcs_pkg::ADDR_W-1:0] ea;
      logic [fcs_pkg::SECT_N-1:0] esel;
      logic is_prog;
      logic tog6;
      logic tog2;
      logic tle;
      logic [fcs_pkg::DATA_W-1:0] rdata;
      logic rvalid;
      logic bsy;
   } fcs_dev_s;

   fcs_dev_s r, nxt;
   logic [fcs_pkg::DATA_W-1:0] mem_r [fcs_pkg::DEPTH];
   logic mem_we;
   logic [fcs_pkg::ADDR_W-1:0] mem_wa;
   logic [fcs_pkg::DATA_W-1:0] mem_wd;
   logic [fcs_pkg::SECT_N-1:0] rsect;
   logic [fcs_pkg::DATA_W-1:0] rword;
   logic in_sel;

   // Stored word at the read address, its sector and whether that sector is being erased
   assign rword = mem_r[bus.addr];
   assign rsect = fcs_pkg::SECT_N'(1) << bus.addr[fcs_pkg::ADDR_W-1:fcs_pkg::SECT_SHIFT];
   assign in_sel = |(rsect & r.esel);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      nxt = r;
      nxt.rvalid = 1'b0;
      mem_we = 1'b0;
      mem_wa = r.ea;
      mem_wd = '0;
      unique case (r.st)
         ST_IDLE, ST_FAIL, ST_SUSP: begin
            if (bus.wr) begin
               // R10 reset command
               if (bus.wdata == fcs_pkg::CMD_RESET) begin
                  nxt.cyc = '0;
                  nxt.tle = 1'b0;
                  // A suspended sector erase is abandoned as well, so that sector must be erased again
                  nxt.st = ST_IDLE;
                  nxt.esel = '0;
               end else if (r.st == ST_SUSP) begin
                  if (bus.wdata == fcs_pkg::CMD_RESUME) nxt.st = ST_ERASE;
               // R23 sequence decode
               end else begin
                  nxt.cyc = '0;
                  unique case (r.cyc)
                     3'h0, 3'h3: if (bus.wdata == fcs_pkg::UNLOCK_A1) nxt.cyc = r.cyc + 3'h1;
                     3'h1, 3'h4: if (bus.wdata == fcs_pkg::UNLOCK_A2) nxt.cyc = r.cyc + 3'h1;
                     3'h2: begin
                        if (bus.wdata == fcs_pkg::CMD_PROG) nxt.cyc = 3'h6;
                        if (bus.wdata == fcs_pkg::CMD_ERASE) nxt.cyc = 3'h3;
                     end
                     // R11 fourth cycle program
                     3'h6: begin
                        nxt.st = ST_PROG;
                        // R12 one byte captured
                        nxt.pa = bus.addr;
                        nxt.pd = bus.wdata;
                        nxt.tmr = '0;
                        nxt.is_prog = 1'b1;
                     end
                     // R18 sixth cycle erase
                     3'h5: begin
                        // R20 all sectors enabled
                        if (bus.wdata == fcs_pkg::CMD_CHIP && &bus.sect_wen) begin
                           nxt.st = ST_PREP;
                           nxt.esel = '1;
                           nxt.ea = '0;
                           nxt.tmr = '0;
                           nxt.is_prog = 1'b0;
                        end else if (bus.wdata == fcs_pkg::CMD_SECT) begin
                           nxt.st = ST_ERASE;
                           nxt.esel = rsect;
                           nxt.ea = '0;
                           nxt.tmr = '0;
                           nxt.is_prog = 1'b0;
                        end
                     end
                     default: nxt.cyc = '0;
                  endcase
               end
            end
         end
         // R14 commands ignored, R13 clears only
         ST_PROG: begin
            nxt.tmr = r.tmr + fcs_pkg::CNT_W'(1);
            if (r.tmr == fcs_pkg::CNT_W'(fcs_pkg::PROG_CYC)) begin
               mem_we = 1'b1;
               mem_wa = r.pa;
               mem_wd = mem_r[r.pa] & r.pd;
               // R07 self return
               if ((mem_r[r.pa] & r.pd) == r.pd) nxt.st = ST_IDLE;
            end
            // R22 time limit
            if (r.tmr == fcs_pkg::CNT_W'(fcs_pkg::LIMIT_CYC)) begin
               nxt.st = ST_FAIL;
               nxt.tle = 1'b1;
            end
         end
         // R19 preprogram zeros
         ST_PREP: begin
            mem_we = 1'b1;
            mem_wd = '0;
            nxt.ea = r.ea + fcs_pkg::ADDR_W'(1);
            if (r.ea == '1) nxt.st = ST_ERASE;
         end
         ST_ERASE: begin
            if (bus.wr && bus.wdata == fcs_pkg::CMD_SUSP && !(&r.esel)) nxt.st = ST_SUSP;
            else begin
               if (|((fcs_pkg::SECT_N'(1) << r.ea[fcs_pkg::ADDR_W-1:fcs_pkg::SECT_SHIFT]) & r.esel)) begin
                  mem_we = 1'b1;
                  mem_wd = '1;
               end
               nxt.ea = r.ea + fcs_pkg::ADDR_W'(1);
               if (r.ea == '1) begin
                  nxt.st = ST_IDLE;
                  nxt.esel = '0;
               end
            end
         end
         default: nxt.st = ST_IDLE;
      endcase
      // Status read path
      if (bus.rd) begin
         nxt.rvalid = 1'b1;
         // R09 idle reads array
         nxt.rdata = rword;
         if (r.st == ST_PROG || (r.st == ST_FAIL && r.is_prog)) begin
            // R05 program flags, R16 together with timeout
            nxt.rdata[fcs_pkg::POS_POLL] = ~r.pd[fcs_pkg::POS_POLL];
            // R17 toggle freezes on timeout
            nxt.rdata[fcs_pkg::POS_BUSY] = r.tog6;
            if (r.st == ST_PROG) nxt.tog6 = ~r.tog6;
            nxt.rdata[fcs_pkg::POS_TLE] = r.tle;
            // R06 program failure reads 0
            nxt.rdata[fcs_pkg::POS_EST] = 1'b0;
         end else if (r.st != ST_IDLE) begin
            nxt.rdata[fcs_pkg::POS_POLL] = 1'b0;
            nxt.rdata[fcs_pkg::POS_BUSY] = r.tog6;
            if (r.st != ST_FAIL && r.st != ST_SUSP) nxt.tog6 = ~r.tog6;
            nxt.rdata[fcs_pkg::POS_TLE] = r.tle;
            // R01 R03 R06 toggle selected, R02 R04 stored bit
            if (in_sel) begin
               nxt.rdata[fcs_pkg::POS_EST] = r.tog2;
               nxt.tog2 = ~r.tog2;
            end
            if (r.st == ST_SUSP && !in_sel) nxt.rdata = rword;
         end
      end
      // Busy view registered so that the ports come from a flip-flop
      nxt.bsy = (nxt.st != ST_IDLE) && (nxt.st != ST_FAIL);
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      // R08 reset to idle
      if (!nrst) begin
         r <= '{st: ST_IDLE, default: '0};
      end else begin
         r <= nxt;
      end
   end

   // Array storage; erased contents read as all ones
   always_ff @(posedge mclk) begin
      if (mem_we) begin
         mem_r[mem_wa] <= mem_wd;
      end
   end

   assign bus.rdata = r.rdata;
   assign bus.rvalid = r.rvalid;
   assign bus.busy = r.bsy;
   assign algo_busy = r.bsy;
   assign timed_out = r.tle;
endmodule
`default_nettype wire

// File: logic/fcs_cpu.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_cpu (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Device side
   fcs_if.cpu bus,
   // User requests
   input wire logic req_prog,
   input wire logic req_chip,
   input wire logic req_reset,
   input wire logic [7:0] req_addr,
   input wire logic [7:0] req_data,
   input wire logic [3:0] wen_in,
   // User status
   output logic done,
   output logic failed,
   output logic idle
);
   typedef enum logic [2:0] {
      CS_IDLE = 3'h1,
      CS_SEND = 3'h2,
      CS_POLL = 3'h4
   } fcs_cpu_e;

   typedef struct packed {
      fcs_cpu_e st;
      logic [2:0] idx;
      logic [2:0] len;
      logic chip;
      logic [7:0] a;
      logic [7:0] d;
      logic wr;
      logic rd;
      logic [7:0] wd;
      logic done;
      logic failed;
      logic tle_seen;
      logic idl;
   } fcs_cpu_s;

   fcs_cpu_s r, nxt;
   logic [7:0] seq_byte;

   // Command byte for each write of the sequence
   always_comb begin
      unique case (r.idx)
         3'h0, 3'h3: seq_byte = fcs_pkg::UNLOCK_A1;
         3'h1, 3'h4: seq_byte = fcs_pkg::UNLOCK_A2;
         3'h2: seq_byte = r.chip ? fcs_pkg::CMD_ERASE : fcs_pkg::CMD_PROG;
         default: seq_byte = r.chip ? fcs_pkg::CMD_CHIP : r.d;
      endcase
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      nxt = r;
      nxt.wr = 1'b0;
      nxt.rd = 1'b0;
      nxt.done = 1'b0;
      unique case (r.st)
         CS_IDLE: begin
            // R10 recovery after failure
            if (req_reset) begin
               nxt.wr = 1'b1;
               nxt.wd = fcs_pkg::CMD_RESET;
               nxt.failed = 1'b0;
            end else if (req_prog || req_chip) begin
               nxt.st = CS_SEND;
               nxt.chip = req_chip;
               nxt.a = req_addr;
               nxt.d = req_data;
               nxt.idx = '0;
               nxt.len = req_chip ? 3'h5 : 3'h3;
               nxt.tle_seen = 1'b0;
            end
         end
         // R11 back to back writes
         CS_SEND: begin
            nxt.wr = 1'b1;
            nxt.wd = seq_byte;
            if (r.idx == 3'h3 && !r.chip) nxt.wd = r.d;
            nxt.idx = r.idx + 3'h1;
            if (r.idx == r.len) nxt.st = CS_POLL;
         end
         // R15 poll last address, R16 R17 recheck after timeout
         CS_POLL: begin
            nxt.rd = !r.rd && !bus.rvalid;
            // An answer read just before the end still carries busy flags, so a mismatch is read once more
            if (bus.rvalid && !bus.busy) begin
               if (r.chip || bus.rdata[fcs_pkg::POS_POLL] == r.d[fcs_pkg::POS_POLL]) begin
                  nxt.st = CS_IDLE;
                  nxt.done = 1'b1;
               end else if (r.tle_seen && bus.rdata[fcs_pkg::POS_TLE]) begin
                  nxt.st = CS_IDLE;
                  nxt.failed = 1'b1;
               end
               nxt.tle_seen = 1'b1;
            end
         end
         default: nxt.st = CS_IDLE;
      endcase
      // Idle view registered so that the port comes from a flip-flop
      nxt.idl = (nxt.st == CS_IDLE);
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      // R21 reset clears state; data is then untrusted
      if (!nrst) begin
         r <= '{st: CS_IDLE, idl: 1'b1, default: '0};
      end else begin
         r <= nxt;
      end
   end

   assign bus.wr = r.wr;
   assign bus.rd = r.rd;
   assign bus.addr = r.a;
   assign bus.wdata = r.wd;
   assign bus.sect_wen = wen_in;
   assign done = r.done;
   assign failed = r.failed;
   assign idle = r.idl;
endmodule
`default_nettype wire

// File: sim/fcs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_asserts (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Bus signals
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   input wire logic [3:0] sect_wen,
   input wire logic busy
);
   // --------------------------------
   // Helper state
   // --------------------------------
   logic [7:0] w1_r;
   logic [7:0] w2_r;
   logic est_r;
   logic seen_r;
   logic prog_m;
   // Program mode read from the stored opcode, so no address decode is needed
   assign prog_m = (w2_r == fcs_pkg::CMD_PROG);

   // Last two written bytes, last erase flag and whether this busy operation was read yet
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         w1_r <= 8'h00;
         w2_r <= 8'h00;
         est_r <= 1'b0;
         seen_r <= 1'b0;
      end else begin
         if (wr) begin
            w1_r <= wdata;
            w2_r <= w1_r;
         end
         if (rvalid) begin
            est_r <= rdata[fcs_pkg::POS_EST];
         end
         seen_r <= busy & (seen_r | rvalid);
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   // --------------------------------
   // Assertions
   // --------------------------------
   a_rvalid_after_rd:
      assert property (rd |=> rvalid) else $error("read not answered");
   a_rvalid_has_cause:
      assert property (rvalid |-> $past(rd)) else $error("answer without read");
   a_reset_idle_state:
      assert property ($rose(nrst) |-> !busy) else $error("busy after reset");
   a_prog_fourth_start:
      assert property (wr && w1_r == fcs_pkg::CMD_PROG && w2_r == fcs_pkg::UNLOCK_A2 && !busy |=> busy)
         else $error("program did not start");
   a_chip_sixth_start:
      assert property (wr && wdata == fcs_pkg::CMD_CHIP && w1_r == fcs_pkg::UNLOCK_A2
         && w2_r == fcs_pkg::UNLOCK_A1 && (&sect_wen) && !busy |=> busy) else $error("chip erase did not start");
   a_prog_est_zero:
      assert property (rvalid && busy && $past(busy) && prog_m |-> !rdata[fcs_pkg::POS_EST])
         else $error("erase flag set in program");
   a_erase_flag_toggle:
      assert property (rvalid && busy && seen_r && !prog_m |-> rdata[fcs_pkg::POS_EST] != est_r)
         else $error("erase flag not toggling");
   a_poll_inverted_data:
      assert property (rvalid && busy && $past(busy) && prog_m && !rdata[fcs_pkg::POS_TLE]
         |-> rdata[fcs_pkg::POS_POLL] == ~w1_r[7]) else $error("polling flag wrong");

   // Main scenarios reached
   c_prog: cover property ($rose(busy) && prog_m);
   c_chip: cover property ($rose(busy) && !prog_m);
   c_tle: cover property (rvalid && rdata[fcs_pkg::POS_TLE]);
endmodule
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // --------------------------------
   // Clock, reset and instances
   // --------------------------------
   localparam logic [15:0] UNL = {fcs_pkg::UNLOCK_A1, fcs_pkg::UNLOCK_A2};
   localparam logic [23:0] PRG = {UNL, fcs_pkg::CMD_PROG};
   localparam logic [47:0] CHIP = {UNL, fcs_pkg::CMD_ERASE, UNL, fcs_pkg::CMD_CHIP};
   localparam logic [47:0] SECT = {UNL, fcs_pkg::CMD_ERASE, UNL, fcs_pkg::CMD_SECT};
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic req_prog, req_chip, req_reset, done, failed, idle, tmo_b, tmo_a, abusy_b;
   logic [7:0] req_addr, req_data, d, e;
   logic [3:0] wen_in;
   int error_cnt = 0;
   int num_checks = 0;
   fcs_if bus_a();
   fcs_if bus_b();

   always #5 mclk = ~mclk;

   fcs_device fcs_device_i (.mclk(mclk), .nrst(nrst), .bus(bus_a), .algo_busy(), .timed_out(tmo_a));
   fcs_cpu fcs_cpu_i (.mclk(mclk), .nrst(nrst), .bus(bus_a), .req_prog(req_prog), .req_chip(req_chip),
      .req_reset(req_reset), .req_addr(req_addr), .req_data(req_data), .wen_in(wen_in), .done(done),
      .failed(failed), .idle(idle));
   // Second device driven directly, so status reads can be aimed anywhere
   fcs_device fcs_device_b_i (.mclk(mclk), .nrst(nrst), .bus(bus_b), .algo_busy(abusy_b), .timed_out(tmo_b));
   fcs_asserts fcs_asserts_i (.mclk(mclk), .nrst(nrst), .wr(bus_a.wr), .rd(bus_a.rd), .wdata(bus_a.wdata),
      .rdata(bus_a.rdata), .rvalid(bus_a.rvalid), .sect_wen(bus_a.sect_wen), .busy(bus_a.busy));

   // --------------------------------
   // Tasks
   // --------------------------------
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Back-to-back writes, first byte in the top lane; wr drops one cycle after
   task automatic wseq(input int n, input logic [7:0] a, input logic [47:0] dv);
      for (int i = n - 1; i >= 0; i--) begin
         bus_b.wr = 1'b1;
         bus_b.addr = a;
         bus_b.wdata = dv[i*8+:8];
         @(negedge mclk);
      end
      bus_b.wr = 1'b0;
      @(negedge mclk);
   endtask

   // One-cycle read strobe; the extra cycle keeps strobes apart
   task automatic rdb(input logic [7:0] a, output logic [7:0] q);
      bus_b.rd = 1'b1;
      bus_b.addr = a;
      @(negedge mclk);
      bus_b.rd = 1'b0;
      for (int i = 0; i < 4 && bus_b.rvalid !== 1'b1; i++) @(negedge mclk);
      q = bus_b.rdata;
      @(negedge mclk);
   endtask

   task automatic wait_b;
      for (int i = 0; i < 6000 && bus_b.busy !== 1'b0; i++) @(negedge mclk);
   endtask

   // Request order is program, chip, reset; waits for the outcome
   task automatic go(input logic [2:0] r, input logic [7:0] a, input logic [7:0] dv);
      {req_prog, req_chip, req_reset} = r;
      req_addr = a;
      req_data = dv;
      @(negedge mclk);
      {req_prog, req_chip, req_reset} = 3'b000;
      @(negedge mclk);
      for (int i = 0; i < 6000 && done !== 1'b1 && failed !== 1'b1 && !(r[0] && idle === 1'b1); i++)
         @(negedge mclk);
   endtask

   // --------------------------------
   // Sequence
   // --------------------------------
   initial begin
      {bus_b.wr, bus_b.rd, bus_b.addr, bus_b.wdata, bus_b.sect_wen} = {18'h0, 4'hF};
      {req_prog, req_chip, req_reset, req_addr, req_data, wen_in} = {19'h0, 4'hF};
      repeat (6) @(negedge mclk);
      nrst = 1'b1;
      @(negedge mclk);
      chk("idle", bus_b.busy, 0);
      wseq(3, 8'h00, {UNL, 8'h77});
      chk("bad seq", bus_b.busy, 0);
      bus_b.sect_wen = 4'h7;
      wseq(6, 8'h00, CHIP);
      chk("chip wen", bus_b.busy, 0);
      bus_b.sect_wen = 4'hF;
      wseq(6, 8'h00, CHIP);
      chk("chip go", bus_b.busy, 1);
      chk("algo busy", abusy_b, 1);
      rdb(8'h00, d);
      rdb(8'h00, e);
      chk("chip tog", d[2] ^ e[2], 1);
      wait_b();
      rdb(8'h45, d);
      chk("erased", d, 8'hFF);
      wseq(4, 8'h3F, {PRG, 8'h5A});
      rdb(8'h3F, d);
      chk("prog st", d & 8'h84, 8'h80);
      // Ignored while busy: a taken write would clear 0x40 for good
      wseq(4, 8'h40, {PRG, 8'h00});
      wait_b();
      wseq(4, 8'h40, {PRG, 8'hA5});
      wait_b();
      rdb(8'h3F, d);
      chk("prog 3F", d, 8'h5A);
      rdb(8'h40, d);
      chk("prog 40", d, 8'hA5);
      // Cleared byte in the target sector, so the erase has something to undo
      wseq(4, 8'hC1, {PRG, 8'h00});
      wait_b();
      wseq(6, 8'hC0, SECT);
      rdb(8'h40, d);
      chk("unsel", d[2], 1);
      rdb(8'hC0, d);
      rdb(8'hC0, e);
      chk("sel tog", d[2] ^ e[2], 1);
      wseq(1, 8'hC0, fcs_pkg::CMD_SUSP);
      rdb(8'hC0, d);
      rdb(8'hC0, e);
      chk("susp tog", d[2] ^ e[2], 1);
      rdb(8'h40, d);
      chk("susp unsel", d[2], 1);
      wseq(1, 8'hC0, fcs_pkg::CMD_RESUME);
      wait_b();
      rdb(8'hC1, d);
      chk("sect erased", d, 8'hFF);
      wseq(4, 8'h3F, {PRG, 8'hFF});
      rdb(8'h3F, d);
      chk("tle low", d & 8'hA4, 8'h00);
      for (int i = 0; i < 5000 && tmo_b !== 1'b1; i++) @(negedge mclk);
      chk("tmo flag", {tmo_b, abusy_b}, 8'h02);
      rdb(8'h3F, d);
      rdb(8'h3F, e);
      chk("tle high", d & 8'hA4, 8'h20);
      chk("busy held", d[6] ^ e[6], 0);
      wseq(1, 8'h00, fcs_pkg::CMD_RESET);
      rdb(8'h3F, d);
      chk("after rst", d, 8'h5A);
      go(3'b010, 8'h00, 8'h00);
      chk("cpu chip", done, 1);
      go(3'b100, 8'h81, 8'h3C);
      chk("cpu prog", {done, failed}, 8'h02);
      go(3'b100, 8'h81, 8'hFF);
      chk("cpu fail", failed, 1);
      chk("cpu tmo", tmo_a, 1);
      go(3'b001, 8'h00, 8'h00);
      chk("cpu idle", {idle, bus_a.busy}, 8'h02);
      chk("cpu tmo clr", tmo_a, 0);
      report_and_stop();
   end

   // Cuts a hang short; the full run needs about 10k cycles
   initial begin
      #500000;
      error_cnt++;
      report_and_stop();
   end
endmodule
`default_nettype wire
